//--- design/csp_regs.svh
`ifndef CSP_REGS_SVH
`define CSP_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define CSP_OFF_CTRL     8'h00
`define CSP_OFF_TXD      8'h04
`define CSP_OFF_RXD      8'h08
`define CSP_OFF_STAT     8'h0c
`define CSP_OFF_BR_BASE  8'h40

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CSP_CTRL_WLEN_LO 0
`define CSP_CTRL_WLEN_HI 3
`define CSP_STAT_LOWPWR  0
`define CSP_STAT_EXTSEQ  1
`define CSP_STAT_REFHALF 2
`define CSP_STAT_RXDONE  3
`define CSP_STAT_AOUTEN  4
`define CSP_ADDR_RW_BIT  7
`define CSP_BR0_EXTSEQ   7
`define CSP_BR2_REFHALF  7
`define CSP_BR2_AOUTEN   0

// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define CSP_WLEN_RST     4'h4
`define CSP_BR_RST       8'h00
`define CSP_MCLK_KHZ     20480
`define CSP_SEQ_KHZ      256
`define CSP_CP_BITS      16

`endif

//--- design/csp_pkg.sv
package csp_pkg;

  // Control port phase, one-hot
  typedef enum logic [2:0]
  {
    CSP_CP_ADDR  = 3'b001,
    CSP_CP_WDATA = 3'b010,
    CSP_CP_RDATA = 3'b100
  } csp_cp_state_t;

  typedef logic [7:0] csp_byte_t;

  // AXI response codes
  typedef enum logic [1:0]
  {
    CSP_RESP_OKAY   = 2'b00,
    CSP_RESP_SLVERR = 2'b10
  } csp_resp_t;

endpackage

//--- design/csp_edge.sv
`timescale 1ns/100ps

module csp_edge
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);

  logic prev_r;
  logic prev_nxt;

  // ----------------------------------------------------------------
  // Edge detection on a pin sampled on aclk
  // ----------------------------------------------------------------

  // Previous sample
  always_comb
  begin
    prev_nxt = pin;
  end

  always_ff @(posedge aclk)
  begin
    // Follow the pin in reset so a pin idling high gives no false edge
    if (!aresetn)
      prev_r <= pin;
    else
      prev_r <= prev_nxt;
  end

  // Edge pulses
  assign rise = pin & ~prev_r;
  assign fall = ~pin & prev_r;

endmodule

//--- design/csp_top.sv
`timescale 1ns/100ps
`include "csp_regs.svh"

module csp_top
#(
  parameter int ADDR_W   = 8,
  parameter int MCLK_DIV = `CSP_MCLK_KHZ / `CSP_SEQ_KHZ
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ctrl_port_select_n,
  input  wire logic        ctrl_port_clock,
  input  wire logic        ctrl_port_in,
  output logic             ctrl_port_out,
  output logic             ctrl_port_out_oe,
  input  wire logic        tx_frame_sync,
  input  wire logic        tx_bit_clock,
  output logic             tx_serial_out,
  output logic             tx_serial_out_oe,
  input  wire logic        rx_frame_sync,
  input  wire logic        rx_bit_clock,
  input  wire logic        rx_serial_in,
  input  wire logic        dsp_master_clock,
  output logic             seq_clock,
  input  wire logic        powerdown_reset_in,
  output logic             low_power,
  output logic             adpcm_reset,
  output logic             analog_out_en,
  output logic             ref_half_supply
);
  import csp_pkg::*;

  localparam int HALF_DIV = MCLK_DIV / 2;

  // Refuse configurations the logic cannot serve
  if (ADDR_W < 8 || MCLK_DIV < 2 || (MCLK_DIV % 2) != 0
      || MCLK_DIV > 131072)
  begin
    $error("csp_top: bad ADDR_W or MCLK_DIV");
  end

  // ----------------------------------------------------------------
  // Pin edge detectors
  // ----------------------------------------------------------------
  logic cpc_rise, cpc_fall, txb_rise, rxb_fall, txf_rise, rxf_rise;
  logic mck_rise, pdr_rise;

  csp_edge u_cpc (.aclk(aclk), .aresetn(aresetn), .pin(ctrl_port_clock),
                  .rise(cpc_rise), .fall(cpc_fall));
  csp_edge u_txb (.aclk(aclk), .aresetn(aresetn), .pin(tx_bit_clock),
                  .rise(txb_rise), .fall());
  csp_edge u_rxb (.aclk(aclk), .aresetn(aresetn), .pin(rx_bit_clock),
                  .rise(), .fall(rxb_fall));
  csp_edge u_txf (.aclk(aclk), .aresetn(aresetn), .pin(tx_frame_sync),
                  .rise(txf_rise), .fall());
  csp_edge u_rxf (.aclk(aclk), .aresetn(aresetn), .pin(rx_frame_sync),
                  .rise(rxf_rise), .fall());
  csp_edge u_mck (.aclk(aclk), .aresetn(aresetn), .pin(dsp_master_clock),
                  .rise(mck_rise), .fall());
  csp_edge u_pdr (.aclk(aclk), .aresetn(aresetn),
                  .pin(powerdown_reset_in), .rise(pdr_rise), .fall());

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  csp_byte_t     br_r [16];
  csp_byte_t     br_nxt [16];
  csp_cp_state_t cp_st_r, cp_st_nxt;
  logic [3:0]    cp_cnt_r, cp_cnt_nxt, cp_addr_r, cp_addr_nxt;
  csp_byte_t     cp_sh_r, cp_sh_nxt, cp_osh_r, cp_osh_nxt;
  logic          cp_out_r, cp_out_nxt;
  csp_byte_t     cp_byte;
  logic          cp_sel, cp_wr_en;
  logic [3:0]    wlen_r, wlen_nxt;
  csp_byte_t     txd_r, txd_nxt, rxd_r, rxd_nxt;
  csp_byte_t     tx_sh_r, tx_sh_nxt, rx_sh_r, rx_sh_nxt;
  logic [3:0]    tx_cnt_r, tx_cnt_nxt, rx_cnt_r, rx_cnt_nxt;
  logic          tx_busy_r, tx_busy_nxt, tx_oe_r, tx_oe_nxt;
  logic          tx_out_r, tx_out_nxt;
  logic          rx_busy_r, rx_busy_nxt, rx_done_r, rx_done_nxt;
  logic          lp_r, lp_nxt, arst_r, arst_nxt;
  logic          aen_r, aen_nxt, ref_r, ref_nxt;
  logic [15:0]   div_r, div_nxt;
  logic          mseq_r, mseq_nxt, seq_r, seq_nxt;
  logic          aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt;
  logic [ADDR_W-1:0] awa_r, awa_nxt;
  logic [31:0]   wd_r, wd_nxt, rd_r, rd_nxt;
  logic          bv_r, bv_nxt, rv_r, rv_nxt;
  logic [1:0]    br_resp_r, br_resp_nxt, rr_resp_r, rr_resp_nxt;
  logic          do_wr, ar_take;
  logic          ws_r, ws_nxt;

  assign cp_sel  = ~ctrl_port_select_n;
  assign cp_byte = {cp_sh_r[6:0], ctrl_port_in};
  assign do_wr   = aw_ok_r & w_ok_r & ~bv_r;
  assign ar_take = s_axi_arvalid & ~rv_r;

  // ----------------------------------------------------------------
  // Control port, power and sequencing next state
  // ----------------------------------------------------------------
  always_comb
  begin
    br_nxt      = br_r;
    cp_st_nxt   = cp_st_r;
    cp_cnt_nxt  = cp_cnt_r;
    cp_addr_nxt = cp_addr_r;
    cp_sh_nxt   = cp_sh_r;
    cp_osh_nxt  = cp_osh_r;
    cp_out_nxt  = cp_out_r;
    cp_wr_en    = 1'b0;
    if (cp_sel && cpc_rise)
    begin
      cp_cnt_nxt = cp_cnt_r + 4'h1;
      case (cp_st_r)
        CSP_CP_ADDR:
        begin
          cp_sh_nxt = cp_byte;
          if (cp_cnt_r == 4'h7)
          begin
            cp_addr_nxt = cp_byte[3:0];
            cp_osh_nxt  = br_r[cp_byte[3:0]];
            if (cp_byte[`CSP_ADDR_RW_BIT])
              cp_st_nxt = CSP_CP_RDATA;
            else
              cp_st_nxt = CSP_CP_WDATA;
          end
        end
        CSP_CP_WDATA:
        begin
          cp_sh_nxt = cp_byte;
          if (cp_cnt_r == 4'hf)
          begin
            cp_wr_en  = 1'b1;
            cp_st_nxt = CSP_CP_ADDR;
          end
        end
        CSP_CP_RDATA:
        begin
          if (cp_cnt_r == 4'hf)
            cp_st_nxt = CSP_CP_ADDR;
        end
        default:
        begin
          cp_st_nxt  = CSP_CP_ADDR;
          cp_cnt_nxt = 4'h0;
        end
      endcase
    end
    if (cp_sel && cpc_fall && cp_st_r == CSP_CP_RDATA)
    begin
      cp_out_nxt = cp_osh_r[7];
      cp_osh_nxt = {cp_osh_r[6:0], 1'b0};
    end
    if (cp_wr_en)
      br_nxt[cp_addr_r] = cp_byte;
    lp_nxt   = ~powerdown_reset_in;
    arst_nxt = pdr_rise;
    ref_nxt  = br_r[2][`CSP_BR2_REFHALF];
    aen_nxt  = br_r[2][`CSP_BR2_AOUTEN] & ~lp_r;
    div_nxt  = div_r;
    mseq_nxt = mseq_r;
    if (mck_rise)
    begin
      if (div_r == 16'(HALF_DIV - 1))
      begin
        div_nxt  = 16'h0000;
        mseq_nxt = ~mseq_r;
      end
      else
        div_nxt = div_r + 16'h0001;
    end
    if (br_r[0][`CSP_BR0_EXTSEQ])
      seq_nxt = rx_bit_clock;
    else
      seq_nxt = mseq_r;
  end

  // ----------------------------------------------------------------
  // Serial data ports next state
  // ----------------------------------------------------------------
  always_comb
  begin
    tx_sh_nxt   = tx_sh_r;
    tx_cnt_nxt  = tx_cnt_r;
    tx_busy_nxt = tx_busy_r;
    tx_oe_nxt   = tx_oe_r;
    tx_out_nxt  = tx_out_r;
    rx_sh_nxt   = rx_sh_r;
    rx_cnt_nxt  = rx_cnt_r;
    rx_busy_nxt = rx_busy_r;
    rxd_nxt     = rxd_r;
    rx_done_nxt = rx_done_r;
    // Write-one clear of the receive flag; a new word wins
    if (do_wr && awa_r[7:0] == `CSP_OFF_STAT && ws_r
        && wd_r[`CSP_STAT_RXDONE])
      rx_done_nxt = 1'b0;
    if (txf_rise)
    begin
      tx_sh_nxt   = txd_r << (4'h8 - wlen_r);
      tx_cnt_nxt  = 4'h0;
      tx_busy_nxt = 1'b1;
    end
    else if (tx_busy_r && txb_rise)
    begin
      if (tx_cnt_r == wlen_r)
      begin
        tx_busy_nxt = 1'b0;
        tx_oe_nxt   = 1'b0;
      end
      else
      begin
        tx_out_nxt = tx_sh_r[7];
        tx_oe_nxt  = 1'b1;
        tx_sh_nxt  = {tx_sh_r[6:0], 1'b0};
        tx_cnt_nxt = tx_cnt_r + 4'h1;
      end
    end
    if (rxf_rise)
    begin
      rx_cnt_nxt  = 4'h0;
      rx_busy_nxt = 1'b1;
    end
    else if (rx_busy_r && rxb_fall)
    begin
      rx_sh_nxt  = {rx_sh_r[6:0], rx_serial_in};
      rx_cnt_nxt = rx_cnt_r + 4'h1;
      if (rx_cnt_r + 4'h1 == wlen_r)
      begin
        rxd_nxt     = {rx_sh_r[6:0], rx_serial_in};
        rx_busy_nxt = 1'b0;
        rx_done_nxt = 1'b1;
      end
    end
    if (lp_r || arst_r)
    begin
      tx_busy_nxt = 1'b0;
      tx_oe_nxt   = 1'b0;
      rx_busy_nxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave next state
  // ----------------------------------------------------------------
  always_comb
  begin
    aw_ok_nxt   = aw_ok_r;
    w_ok_nxt    = w_ok_r;
    awa_nxt     = awa_r;
    wd_nxt      = wd_r;
    ws_nxt      = ws_r;
    bv_nxt      = bv_r;
    br_resp_nxt = br_resp_r;
    rv_nxt      = rv_r;
    rd_nxt      = rd_r;
    rr_resp_nxt = rr_resp_r;
    wlen_nxt    = wlen_r;
    txd_nxt     = txd_r;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_ok_nxt = 1'b1;
      awa_nxt   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_ok_nxt = 1'b1;
      wd_nxt   = s_axi_wdata;
      ws_nxt   = s_axi_wstrb[0];
    end
    if (do_wr)
    begin
      aw_ok_nxt   = 1'b0;
      w_ok_nxt    = 1'b0;
      bv_nxt      = 1'b1;
      br_resp_nxt = CSP_RESP_OKAY;
      case (awa_r[7:0])
        `CSP_OFF_CTRL:
          if (ws_r)
            wlen_nxt = wd_r[`CSP_CTRL_WLEN_HI:`CSP_CTRL_WLEN_LO];
        `CSP_OFF_TXD:
          if (ws_r)
            txd_nxt = wd_r[7:0];
        `CSP_OFF_STAT: ;
        default:
          br_resp_nxt = CSP_RESP_SLVERR;
      endcase
    end
    else if (bv_r && s_axi_bready)
      bv_nxt = 1'b0;
    if (ar_take)
    begin
      rv_nxt      = 1'b1;
      rd_nxt      = 32'h0000_0000;
      rr_resp_nxt = CSP_RESP_OKAY;
      if (s_axi_araddr[7:6] == 2'b01 && s_axi_araddr[1:0] == 2'b00)
        rd_nxt[7:0] = br_r[s_axi_araddr[5:2]];
      else
        case (s_axi_araddr[7:0])
          `CSP_OFF_CTRL: rd_nxt[3:0] = wlen_r;
          `CSP_OFF_TXD:  rd_nxt[7:0] = txd_r;
          `CSP_OFF_RXD:  rd_nxt[7:0] = rxd_r;
          `CSP_OFF_STAT: rd_nxt[4:0] = {aen_r, rx_done_r, ref_r,
                                        br_r[0][`CSP_BR0_EXTSEQ], lp_r};
          default:       rr_resp_nxt = CSP_RESP_SLVERR;
        endcase
    end
    else if (rv_r && s_axi_rready)
      rv_nxt = 1'b0;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 16; i++)
        br_r[i] <= `CSP_BR_RST;
      cp_st_r <= CSP_CP_ADDR;
      cp_cnt_r <= 4'h0; cp_addr_r <= 4'h0; cp_sh_r <= 8'h00;
      cp_osh_r <= 8'h00; cp_out_r <= 1'b0; wlen_r <= `CSP_WLEN_RST;
      txd_r <= 8'h00; rxd_r <= 8'h00; tx_sh_r <= 8'h00; rx_sh_r <= 8'h00;
      tx_cnt_r <= 4'h0; rx_cnt_r <= 4'h0; tx_busy_r <= 1'b0;
      tx_oe_r <= 1'b0; tx_out_r <= 1'b0; rx_busy_r <= 1'b0;
      rx_done_r <= 1'b0; lp_r <= 1'b0; arst_r <= 1'b0; aen_r <= 1'b0;
      ref_r <= 1'b0; div_r <= 16'h0000; mseq_r <= 1'b0; seq_r <= 1'b0;
      aw_ok_r <= 1'b0; w_ok_r <= 1'b0; awa_r <= '0; wd_r <= 32'h0;
      bv_r <= 1'b0; rv_r <= 1'b0; rd_r <= 32'h0;
      br_resp_r <= 2'h0; rr_resp_r <= 2'h0;
      ws_r <= 1'b0;
    end
    else
    begin
      br_r <= br_nxt;
      cp_st_r <= cp_st_nxt; cp_cnt_r <= cp_cnt_nxt;
      cp_addr_r <= cp_addr_nxt; cp_sh_r <= cp_sh_nxt;
      cp_osh_r <= cp_osh_nxt; cp_out_r <= cp_out_nxt; wlen_r <= wlen_nxt;
      txd_r <= txd_nxt; rxd_r <= rxd_nxt; tx_sh_r <= tx_sh_nxt;
      rx_sh_r <= rx_sh_nxt; tx_cnt_r <= tx_cnt_nxt; rx_cnt_r <= rx_cnt_nxt;
      tx_busy_r <= tx_busy_nxt; tx_oe_r <= tx_oe_nxt;
      tx_out_r <= tx_out_nxt; rx_busy_r <= rx_busy_nxt;
      rx_done_r <= rx_done_nxt; lp_r <= lp_nxt; arst_r <= arst_nxt;
      aen_r <= aen_nxt; ref_r <= ref_nxt; div_r <= div_nxt;
      mseq_r <= mseq_nxt; seq_r <= seq_nxt;
      aw_ok_r <= aw_ok_nxt; w_ok_r <= w_ok_nxt; awa_r <= awa_nxt;
      wd_r <= wd_nxt; bv_r <= bv_nxt; rv_r <= rv_nxt; rd_r <= rd_nxt;
      br_resp_r <= br_resp_nxt; rr_resp_r <= rr_resp_nxt;
      ws_r <= ws_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready    = ~aw_ok_r & ~bv_r;
  assign s_axi_wready     = ~w_ok_r & ~bv_r;
  assign s_axi_bvalid     = bv_r;
  assign s_axi_bresp      = br_resp_r;
  assign s_axi_arready    = ~rv_r;
  assign s_axi_rvalid     = rv_r;
  assign s_axi_rdata      = rd_r;
  assign s_axi_rresp      = rr_resp_r;
  assign ctrl_port_out    = cp_out_r;
  assign ctrl_port_out_oe = cp_sel & (cp_st_r == CSP_CP_RDATA);
  assign tx_serial_out    = tx_out_r;
  assign tx_serial_out_oe = tx_oe_r;
  assign seq_clock        = seq_r;
  assign low_power        = lp_r;
  assign adpcm_reset      = arst_r;
  assign analog_out_en    = aen_r;
  assign ref_half_supply  = ref_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_TX_HIZ: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_serial_out_oe |-> tx_busy_r)
    else $error("transmit pin driven outside a word");
  AST_CP_IGNORE: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_port_select_n |=> $stable(cp_cnt_r) && $stable(cp_st_r))
    else $error("control clock edge taken while deselected");
  AST_CP_RXHOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    cp_st_r == CSP_CP_RDATA |=> $stable(cp_sh_r))
    else $error("control input taken while sending");
  AST_CP_CAPTURE: assert property (@(posedge aclk) disable iff (!aresetn)
    cp_sel && cpc_rise && cp_st_r == CSP_CP_ADDR
    |=> cp_sh_r[0] == $past(ctrl_port_in))
    else $error("control input bit not captured on rise");
  AST_CP_MSB: assert property (@(posedge aclk) disable iff (!aresetn)
    cp_sel && cpc_fall && cp_st_r == CSP_CP_RDATA
    |=> ctrl_port_out == $past(cp_osh_r[7]))
    else $error("read bit not shifted MSB first on fall");
  AST_CP_WR16: assert property (@(posedge aclk) disable iff (!aresetn)
    cp_sel && cpc_rise && cp_st_r == CSP_CP_WDATA && cp_cnt_r == 4'hf
    |=> br_r[$past(cp_addr_r)] == $past(cp_byte))
    else $error("byte register written at wrong bit");
  AST_LOWPWR: assert property (@(posedge aclk) disable iff (!aresetn)
    !powerdown_reset_in |=> low_power ##1 !analog_out_en)
    else $error("power-down not followed");
  AST_ADPCM_RST: assert property (@(posedge aclk) disable iff (!aresetn)
    pdr_rise |=> adpcm_reset ##1 !adpcm_reset && !tx_busy_r)
    else $error("reset pulse missing on power-up edge");
  AST_REF: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 ref_half_supply == $past(br_r[2][7]))
    else $error("reference select does not follow register");
  AST_SEQ_EXT: assert property (@(posedge aclk) disable iff (!aresetn)
    br_r[0][7] |=> seq_clock == $past(rx_bit_clock))
    else $error("external sequencing clock not selected");

endmodule

//--- tb/csp_host_model.sv
`timescale 1ns/100ps

// ------------------------------------------------
// Controller, voice data host and master clock
// ------------------------------------------------
module csp_host_model
(
  input  wire logic aclk,
  output logic      ctrl_port_select_n,
  output logic      ctrl_port_clock,
  output logic      ctrl_port_in,
  input  wire logic ctrl_port_out,
  input  wire logic ctrl_port_out_oe,
  output logic      tx_frame_sync,
  output logic      tx_bit_clock,
  input  wire logic tx_serial_out,
  input  wire logic tx_serial_out_oe,
  output logic      rx_frame_sync,
  output logic      rx_bit_clock,
  output logic      rx_serial_in,
  output logic      dsp_master_clock
);
  // Idle levels: deselected, port clocks standing still
  initial
  begin
    ctrl_port_select_n = 1'b1;
    {ctrl_port_clock, ctrl_port_in, tx_frame_sync, tx_bit_clock} = '0;
    {rx_frame_sync, rx_bit_clock, rx_serial_in, dsp_master_clock} = '0;
  end

  // Master clock, one aclk per level
  always @(posedge aclk) dsp_master_clock <= ~dsp_master_clock;

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Sixteen clocks per transfer, optional break between bytes
  task automatic cp_xfer(input logic [15:0] w, input bit split,
                         output logic [7:0] rd);
    ctrl_port_select_n <= 1'b0;
    tick(4);
    for (int i = 0; i < 16; i++)
    begin
      if (split && i == 8)
      begin
        ctrl_port_select_n <= 1'b1;
        tick(2);
        ctrl_port_clock <= 1'b0;
        tick(2);
        ctrl_port_clock <= 1'b1;
        tick(2);
        ctrl_port_select_n <= 1'b0;
        tick(2);
      end
      ctrl_port_clock <= 1'b0;
      // Noise on the input while the device answers a read
      ctrl_port_in <= (i > 7 && w[15]) ? ~ctrl_port_in : w[15-i];
      tick(4);
      if (i > 7) rd[15-i] = ctrl_port_out_oe ? ctrl_port_out : 1'bx;
      ctrl_port_clock <= 1'b1;
      tick(4);
    end
    ctrl_port_select_n <= 1'b1;
    tick(2);
    ctrl_port_clock <= 1'b0;
    tick(2);
  endtask

  // Transmit frame: sync, then nine bit clock rises
  task automatic tx_frame(output logic [8:0] oe, output logic [7:0] d);
    tx_frame_sync <= 1'b1;
    tick(4);
    for (int i = 0; i < 9; i++)
    begin
      tx_bit_clock <= 1'b1;
      tick(4);
      oe[i] = tx_serial_out_oe;
      if (i < 8) d[7-i] = tx_serial_out;
      tx_bit_clock <= 1'b0;
      tx_frame_sync <= 1'b0;
      tick(4);
    end
  endtask

  // Receive frame, data steady across each falling edge
  task automatic rx_frame(input logic [7:0] d);
    rx_frame_sync <= 1'b1;
    tick(4);
    for (int i = 0; i < 8; i++)
    begin
      rx_serial_in <= d[7-i];
      rx_bit_clock <= 1'b1;
      tick(4);
      rx_bit_clock <= 1'b0;
      tick(4);
    end
    rx_frame_sync <= 1'b0;
    rx_serial_in <= ~d[0];
  endtask

  task automatic set_rxclk(input logic v);
    rx_bit_clock <= v;
  endtask
endmodule

//--- tb/test_codec_serial_ports.sv
`timescale 1ns/100ps
`include "csp_regs.svh"

module test_codec_serial_ports;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, seq_clock;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, b;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [3:0]  s_axi_wstrb;
  logic [8:0]  oe;
  logic        ctrl_port_select_n, ctrl_port_clock, ctrl_port_in;
  logic        ctrl_port_out, ctrl_port_out_oe, tx_serial_out_oe;
  logic        tx_frame_sync, tx_bit_clock, tx_serial_out, rx_frame_sync;
  logic        rx_bit_clock, rx_serial_in, dsp_master_clock, ps;
  logic        powerdown_reset_in, low_power, adpcm_reset;
  logic        analog_out_en, ref_half_supply;
  int          err_total, checked, pulses, p0, n;

  csp_top #(.MCLK_DIV(4)) u_csp_top
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ctrl_port_select_n, .ctrl_port_clock,
    .ctrl_port_in, .ctrl_port_out, .ctrl_port_out_oe, .tx_frame_sync,
    .tx_bit_clock, .tx_serial_out, .tx_serial_out_oe, .rx_frame_sync,
    .rx_bit_clock, .rx_serial_in, .dsp_master_clock, .seq_clock,
    .powerdown_reset_in, .low_power, .adpcm_reset, .analog_out_en,
    .ref_half_supply
  );

  csp_host_model u_csp_host_model
  (
    .aclk, .ctrl_port_select_n, .ctrl_port_clock, .ctrl_port_in,
    .ctrl_port_out, .ctrl_port_out_oe, .tx_frame_sync, .tx_bit_clock,
    .tx_serial_out, .tx_serial_out_oe, .rx_frame_sync, .rx_bit_clock,
    .rx_serial_in, .dsp_master_clock
  );

  // ------------------------------------------------
  // Clock, watchdog, bus tasks and checks
  // ------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  always @(posedge aclk) if (adpcm_reset === 1'b1) pulses++;

  initial
  begin
    repeat (30000) @(posedge aclk);
    err_total++;
    results();
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic results();
    if (err_total == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    powerdown_reset_in = 1'b1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`CSP_OFF_CTRL);
    chk("ctrl reset", `CSP_WLEN_RST, rv);
    axi_rd(8'h80);
    chk("unmapped rresp", 2'b10, rs);
    chk("unmapped rdata", 0, rv);
    axi_wr(8'h80, 32'h1);
    chk("unmapped bresp", 2'b10, rs);
    u_csp_host_model.cp_xfer(16'h035a, 1'b0, b);
    axi_rd(`CSP_OFF_BR_BASE + 8'h0c);
    chk("reg3", 32'h5a, rv);
    u_csp_host_model.cp_xfer(16'h0281, 1'b1, b);
    axi_rd(`CSP_OFF_BR_BASE + 8'h08);
    chk("reg2", 32'h81, rv);
    chk("ref half", 1, ref_half_supply);
    chk("aout en", 1, analog_out_en);
    u_csp_host_model.cp_xfer(16'h8300, 1'b0, b);
    chk("cp read", 8'h5a, b);
    chk("cp oe idle", 0, ctrl_port_out_oe);
    p0 = pulses;
    powerdown_reset_in <= 1'b0;
    u_csp_host_model.tick(4);
    chk("low power", 1, low_power);
    chk("aout off", 0, analog_out_en);
    powerdown_reset_in <= 1'b1;
    u_csp_host_model.tick(4);
    chk("reset pulses", p0 + 1, pulses);
    axi_rd(`CSP_OFF_STAT);
    chk("stat", 32'h14, rv);
    axi_wr(`CSP_OFF_CTRL, 32'h8);
    axi_wr(`CSP_OFF_TXD, 32'ha5);
    chk("wresp", 2'b00, rs);
    s_axi_wstrb <= 4'h0;
    axi_wr(`CSP_OFF_TXD, 32'h5a);
    s_axi_wstrb <= 4'hf;
    axi_rd(`CSP_OFF_TXD);
    chk("txd strobe", 32'ha5, rv);
    chk("tx oe idle", 0, tx_serial_out_oe);
    fork
      u_csp_host_model.tx_frame(oe, b);
      u_csp_host_model.rx_frame(8'h3c);
    join
    chk("tx oe", 9'h0ff, oe);
    chk("tx data", 8'ha5, b);
    axi_rd(`CSP_OFF_RXD);
    chk("rx data", 32'h3c, rv);
    axi_rd(`CSP_OFF_STAT);
    chk("stat done", 32'h1c, rv);
    axi_wr(`CSP_OFF_STAT, 32'h8);
    axi_rd(`CSP_OFF_STAT);
    chk("stat clear", 32'h14, rv);
    n = 0;
    ps = seq_clock;
    repeat (64)
    begin
      @(posedge aclk);
      n += (seq_clock !== ps);
      ps = seq_clock;
    end
    chk("seq toggles", 16, n);
    u_csp_host_model.cp_xfer(16'h0080, 1'b0, b);
    u_csp_host_model.set_rxclk(1'b1);
    u_csp_host_model.tick(4);
    chk("seq ext high", 1, seq_clock);
    u_csp_host_model.set_rxclk(1'b0);
    u_csp_host_model.tick(4);
    chk("seq ext low", 0, seq_clock);
    results();
  end
endmodule
